// ==== core/lbp_regs.svh ====
// constants for the local bus protocol configuration block
// Summary of operation
// - Config bit 7 picks burst-last mode: 0 marks only the final transfer, 1 marks the whole burst until burst-last-in drops;
//   the code pulses burst_last_q once, at burst end, in both modes.
// - Bit 6 picks byte-enable style for 16/32-bit modes: 0 plain per-byte enables, 1 (default) encoded enables.
// - Bits 5:4 at 00 make the read pin a write-not-read direction, at 01 (default) the write pin read-not-write; strobe pin is the address strobe.
// - Bits 5:4 at 1X make read and write pins separate data strobes used as the internal strobe; strobe pin unused.
// - Bit 2 sets strobe polarity: 0 (default) active low, 1 active high.
// - Bit 3 picks the clock edge sampling the internal address strobe: 0 rising, 1 falling.
// - Bit 1 at 0 captures write data in the ready cycle, at 1 one cycle later.
// - Bit 0 at 0 presents read data in the ready cycle, at 1 one cycle later.
`ifndef LBP_REGS_SVH
`define LBP_REGS_SVH
`define LBP_CFG_ADDR       12'h4FC
`define LBP_STAT_ADDR      12'h004
`define LBP_CFG_RESET      32'h0000_8050
`define LBP_CFG_WMASK      32'h0000_80FF
`define LBP_BIT_DOUT_DLY   0
`define LBP_BIT_DIN_DLY    1
`define LBP_BIT_SPOL       2
`define LBP_BIT_SFALL      3
`define LBP_BIT_RW_LO      4
`define LBP_BIT_RW_HI      5
`define LBP_BIT_BESTYLE    6
`define LBP_BIT_BLMODE     7
`define LBP_BIT_XRDY       15
`endif

// ==== core/lbp_pkg.sv ====
// types for the local bus protocol configuration block
package lbp_pkg;
    typedef enum logic [1:0] {
        LBP_IDLE = 2'b00,
        LBP_ADDR = 2'b01,
        LBP_DATA = 2'b11,
        LBP_LATE = 2'b10
    } lbp_state_e;
endpackage

// ==== core/lbp_sync.sv ====
// two-stage synchroniser, one per bit
`timescale 1ns/1ns
module lbp_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    meta_q[i] <= 1'b0;
                    q[i]      <= 1'b0;
                end
                else
                begin
                    meta_q[i] <= d[i];
                    q[i]      <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule

// ==== core/lbp_cfg.sv ====
// local bus protocol configuration and strobe decode
`timescale 1ns/1ns
`include "lbp_regs.svh"
module lbp_cfg (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        local_clock,
    input  wire logic        read_pin,
    input  wire logic        write_pin,
    input  wire logic        strobe_pin,
    input  wire logic        burst_last_in,
    input  wire logic        ready_in,
    input  wire logic        ready_out,
    output logic             addr_strobe_q,
    output logic             is_write_q,
    output logic             burst_last_q,
    output logic             byte_enable_style_q,
    output logic             wdata_capture_q,
    output logic             rdata_present_q,
    output logic             cfg_conflict_q
);
    logic [31:0]         cfg_q;
    logic [6:0]          pins_s;
    logic                lclk_d1_q;
    logic                act_bl_q;
    logic                act_di_q;
    logic                act_do_q;
    logic                act_sf_q;
    logic                act_es_q;
    logic                cap_late_q;
    logic                pres_late_q;
    lbp_pkg::lbp_state_e state_q;
    lbp_pkg::lbp_state_e state_d;

    // local clock is sampled like any pin; edges come out as mclk enables
    lbp_sync #(.W(7)) u_sync (
        .mclk (mclk),
        .nrst (nrst),
        .d    ({local_clock, read_pin, write_pin, strobe_pin, burst_last_in, ready_in, ready_out}),
        .q    (pins_s)
    );

    wire lclk_s   = pins_s[6];
    wire rd_s     = pins_s[5];
    wire wr_s     = pins_s[4];
    wire stb_s    = pins_s[3];
    wire bl_s     = pins_s[2];
    wire rdyi_s   = pins_s[1];
    wire rdyo_s   = pins_s[0];
    wire rise_en  = lclk_s & ~lclk_d1_q;
    wire fall_en  = ~lclk_s & lclk_d1_q;

    // apb decode; one wait state, write lands with pready
    wire acc      = psel & penable;
    wire hit_cfg  = paddr == `LBP_CFG_ADDR;
    wire hit_stat = paddr == `LBP_STAT_ADDR;
    wire wr_cfg   = acc & pready & pwrite & hit_cfg;
    wire [31:0] cfg_d = (pwdata & `LBP_CFG_WMASK) | (cfg_q & ~`LBP_CFG_WMASK);
    wire [31:0] stat_w = {26'h0, state_q, cfg_conflict_q, is_write_q, addr_strobe_q, burst_last_q};
    wire [31:0] rd_mux = hit_cfg ? cfg_q : (hit_stat ? stat_w : 32'h0000_0000);

    // live settings for sampling at transaction start
    wire [1:0] rw_live = cfg_q[`LBP_BIT_RW_HI:`LBP_BIT_RW_LO];
    wire sf_live = cfg_q[`LBP_BIT_SFALL];
    wire sp_live = cfg_q[`LBP_BIT_SPOL];

    // strobe polarity normalised to active high
    wire stb_act  = sp_live ? stb_s : ~stb_s;
    // in 1X mode the data strobes act as the internal strobe (assumed active low)
    wire dstb_act = ~rd_s | ~wr_s;
    wire int_stb  = rw_live[1] ? dstb_act : stb_act;
    wire smp_en   = sf_live ? fall_en : rise_en;
    wire act_en   = act_sf_q ? fall_en : rise_en;
    // direction per mode: 00 read pin high = write, 01 write pin low = write
    wire dir_wr   = rw_live[1] ? ~wr_s : (rw_live[0] ? ~wr_s : rd_s);
    wire handshake = rdyi_s & rdyo_s;
    // whole-burst mode: the final beat is only known once burst-last has dropped
    wire bl_end   = act_bl_q ? ~bl_s : (handshake & bl_s);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            lbp_pkg::LBP_IDLE: if (smp_en && int_stb) state_d = lbp_pkg::LBP_ADDR;
            lbp_pkg::LBP_ADDR: if (act_en) state_d = lbp_pkg::LBP_DATA;
            lbp_pkg::LBP_DATA: if (act_en && bl_end) state_d = lbp_pkg::LBP_LATE;
            lbp_pkg::LBP_LATE: if (act_en) state_d = lbp_pkg::LBP_IDLE;
            default:           state_d = lbp_pkg::LBP_IDLE;
        endcase
    end

    // named beat conditions keep the pulse logic short
    wire in_data   = state_q == lbp_pkg::LBP_DATA;
    wire beat_wr   = in_data & handshake & is_write_q;
    wire beat_rd   = in_data & handshake & ~is_write_q;
    wire start_tx  = (state_q == lbp_pkg::LBP_IDLE) & (state_d == lbp_pkg::LBP_ADDR);
    wire burst_end = in_data & (state_d == lbp_pkg::LBP_LATE);

    // config register; write lands at the edge where the master sees pready
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            cfg_q <= `LBP_CFG_RESET;
        else if (wr_cfg)
            cfg_q <= cfg_d;
    end

    // one wait cycle so the answer is registered; pready pulses once per access
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~(hit_cfg | (hit_stat & ~pwrite));
            prdata  <= rd_mux;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            lclk_d1_q <= 1'b0;
            state_q   <= lbp_pkg::LBP_IDLE;
        end
        else
        begin
            lclk_d1_q <= lclk_s;
            state_q   <= state_d;
        end
    end

    // settings latched per transaction, so a write mid-burst cannot glitch it
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            act_bl_q   <= 1'b0;
            act_sf_q   <= 1'b0;
            act_di_q   <= 1'b0;
            act_do_q   <= 1'b0;
            act_es_q   <= 1'b1;
            is_write_q <= 1'b0;
        end
        else if (start_tx)
        begin
            act_bl_q   <= cfg_q[`LBP_BIT_BLMODE];
            act_sf_q   <= sf_live;
            act_di_q   <= cfg_q[`LBP_BIT_DIN_DLY];
            act_do_q   <= cfg_q[`LBP_BIT_DOUT_DLY];
            act_es_q   <= cfg_q[`LBP_BIT_BESTYLE];
            is_write_q <= dir_wr;
        end
    end

    // strobe, burst end and level outputs
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_strobe_q       <= 1'b0;
            burst_last_q        <= 1'b0;
            byte_enable_style_q <= 1'b1;
            cfg_conflict_q      <= 1'b0;
        end
        else
        begin
            addr_strobe_q       <= smp_en & int_stb & (state_q == lbp_pkg::LBP_IDLE);
            burst_last_q        <= burst_end;
            byte_enable_style_q <= act_es_q;
            // flags illegal combo for software; hardware does not block it
            cfg_conflict_q      <= cfg_q[`LBP_BIT_BLMODE] & cfg_q[`LBP_BIT_XRDY];
        end
    end

    // data pulses; a delayed beat waits in its late flop for the next active local edge
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cap_late_q      <= 1'b0;
            pres_late_q     <= 1'b0;
            wdata_capture_q <= 1'b0;
            rdata_present_q <= 1'b0;
        end
        else if (act_en)
        begin
            cap_late_q      <= beat_wr & act_di_q;
            pres_late_q     <= beat_rd & act_do_q;
            wdata_capture_q <= (beat_wr & ~act_di_q) | cap_late_q;
            rdata_present_q <= (beat_rd & ~act_do_q) | pres_late_q;
        end
        else
        begin
            wdata_capture_q <= 1'b0;
            rdata_present_q <= 1'b0;
        end
    end
endmodule

// ==== verification/lbp_cfg_sva.sv ====
// protocol checker for the local bus protocol configuration block
`timescale 1ns/1ns
module lbp_cfg_sva (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        addr_strobe_q,
    input wire logic        is_write_q,
    input wire logic        wdata_capture_q,
    input wire logic        rdata_present_q,
    input wire logic        cfg_conflict_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire acc = psel && penable && !pready;
    chk_ready_wait: assert property (acc |=> pready) else $error("pready late");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    chk_err_stat: assert property (acc && pwrite && paddr == 12'h004 |=> pslverr) else $error("no err");
    chk_cfg_ok: assert property (acc && paddr == 12'h4FC |=> !pslverr) else $error("cfg err");
    chk_conflict_flag: assert property (acc && pwrite && paddr == 12'h4FC && pwdata[7] && pwdata[15]
        |=> ##[0:2] cfg_conflict_q) else $error("no conflict");
    chk_strobe_pulse: assert property (addr_strobe_q |=> !addr_strobe_q) else $error("strobe held");
    chk_data_excl: assert property (!(wdata_capture_q && rdata_present_q)) else $error("both");
    chk_wcap_dir: assert property (wdata_capture_q |-> is_write_q) else $error("capture on read");
    chk_rdat_dir: assert property (rdata_present_q |-> !is_write_q) else $error("present on write");
endmodule
bind lbp_cfg lbp_cfg_sva u_sva (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .addr_strobe_q(addr_strobe_q),
    .is_write_q(is_write_q), .wdata_capture_q(wdata_capture_q), .rdata_present_q(rdata_present_q),
    .cfg_conflict_q(cfg_conflict_q));

// ==== verification/lbp_cpu.sv ====
// local processor model driving the local bus pins
`timescale 1ns/1ns
module lbp_cpu (
    input wire logic mclk,
    output logic     local_clock,
    output logic     read_pin,
    output logic     write_pin,
    output logic     strobe_pin,
    output logic     burst_last_in,
    output logic     ready_in,
    output logic     ready_out
);
    initial {local_clock, read_pin, write_pin, strobe_pin, burst_last_in, ready_in, ready_out} = 7'b0111000;
    // one local cycle of 10 mclk; low phase longer so pins settle off both edges
    task automatic cyc();
        repeat (4) @(posedge mclk);
        local_clock <= 1'b1;
        repeat (4) @(posedge mclk);
        local_clock <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    // single beat; unused pin shows the contrary level so a misdecode shows
    task automatic xfer(input logic [1:0] mode, input logic pol, input logic wr);
        read_pin <= (mode == 2'b01) ? ~wr : wr;
        write_pin <= (mode == 2'b00) ? wr : ~wr;
        strobe_pin <= mode[1] ? ~pol : pol;
        cyc();
        strobe_pin <= ~pol;
        {ready_in, ready_out, burst_last_in} <= 3'b111;
        // ready stands over two local edges: the first only ends the address phase
        repeat (2) cyc();
        {ready_in, ready_out, burst_last_in, read_pin, write_pin} <= 5'b00011;
        repeat (3) cyc();
    endtask
endmodule

// ==== verification/local_bus_protocol_config_tb.sv ====
// self-checking bench for the local bus protocol configuration block
`timescale 1ns/1ns
module local_bus_protocol_config_tb;
    logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        lclk, rpin, wpin, spin, bl_in, rin, rout, as_q, wr_q, bl_q, bes_q, wc_q, rp_q, cf_q;
    int          n_mismatch, checked, na, nw, nr, nb, lat, base [2];
    // {direction, cfg}: default, pin modes, polarity, edge, delays, whole burst
    logic [8:0]  rows [12] = '{9'h150, 9'h050, 9'h100, 9'h000, 9'h120, 9'h024, 9'h114, 9'h018,
                               9'h112, 9'h011, 9'h012, 9'h1D0};
    lbp_cfg DUT (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .local_clock(lclk),
        .read_pin(rpin), .write_pin(wpin), .strobe_pin(spin), .burst_last_in(bl_in), .ready_in(rin),
        .ready_out(rout), .addr_strobe_q(as_q), .is_write_q(wr_q), .burst_last_q(bl_q),
        .byte_enable_style_q(bes_q), .wdata_capture_q(wc_q), .rdata_present_q(rp_q), .cfg_conflict_q(cf_q));
    lbp_cpu cpu (.mclk(mclk), .local_clock(lclk), .read_pin(rpin), .write_pin(wpin), .strobe_pin(spin),
        .burst_last_in(bl_in), .ready_in(rin), .ready_out(rout));
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // master holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50)
        begin
            n_mismatch++;
            complete_run();
        end
        // let an edge pass so the next setup does not rewrite psel in this step
        @(posedge mclk);
    endtask
    task automatic frame(input logic [8:0] r);
        apb(1'b1, 12'h4FC, {24'h0, r[7:0]}, rd, err);
        {na, nw, nr, nb, lat} = {32'd0, 32'd0, 32'd0, 32'd0, -32'd1};
        fork
            cpu.xfer(r[5:4], r[2], r[8]);
            for (int i = 0; i < 80; i++)
            begin
                @(posedge mclk);
                na += as_q;
                nw += wc_q;
                nr += rp_q;
                nb += bl_q;
                if (lat < 0 && (wc_q || rp_q))
                    lat = i;
            end
        join
        chk("write capture count", 32'(r[8]), nw);
        chk("read present count", 32'(!r[8]), nr);
        chk("burst end count", 1, nb);
        if (!r[5])
            chk("address strobe count", 1, na);
        chk("direction", 32'(r[8]), 32'(wr_q));
        chk("byte enable style", 32'(r[6]), 32'(bes_q));
        if (r[5:2] == 4'h4 && r[1:0] == 2'b00)
            base[r[8]] = lat;
        else if (r[5:2] == 4'h4)
            chk("data latency", base[r[8]] + (r[8] ? r[1] : r[0]) * 10, lat);
    endtask
    initial
    begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {n_mismatch, checked} = '0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        apb(1'b0, 12'h4FC, 32'h0, rd, err);
        chk("cfg reset value", 32'h0000_8050, rd);
        chk("byte enable reset", 1, 32'(bes_q));
        foreach (rows[i]) frame(rows[i]);
        $display("table test done");
        apb(1'b1, 12'h4FC, 32'hFFFF_FFFF, rd, err);
        apb(1'b0, 12'h4FC, 32'h0, rd, err);
        chk("cfg write mask", 32'h0000_80FF, rd);
        chk("conflict flag", 1, 32'(cf_q));
        apb(1'b1, 12'h004, 32'h1, rd, err);
        chk("status write refused", 1, 32'(err));
        apb(1'b0, 12'h00C, 32'h0, rd, err);
        chk("unmapped refused", 1, 32'(err));
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        apb(1'b0, 12'h4FC, 32'h0, rd, err);
        chk("cfg after reset", 32'h0000_8050, rd);
        chk("conflict cleared", 0, 32'(cf_q));
        $display("register test done");
        complete_run();
    end
endmodule
